// ==== rtl/core_memory_cycle_sequencer.sv ====
// Operation
// R1: latch 18-bit address, decode bank and word
// R2: lowest address bit picks the byte
// R3: one X and one Y line enabled
// R4: read and write drive opposite polarity
// R5: stack read state reading, write state writing
// R6: power low blocks current source enable
// R7: four transaction types only
// R8: restore read: read, present, write back
// R9: pause read skips restore, half cycle
// R10: pause read sets pause flag
// R11: master follows pause read with write
// R12: word write: clearing read then write
// R13: pause flag set: write skips read phase
// R14: byte write read keeps other byte
// R15: byte write stores merged word back
// R16: byte write after pause read accepted too
// R17: cycle about 900 ns, access 400 ns
// R18: inhibit every zero bit while writing
// R19: top four address bits match bank
// R20: two control lines pick the type
// R21: write completion clears pause flag
// R22: ack only after data valid or captured
//
// The implementer's own choices: the address-and-strobe port.
`include "core_seq_cfg.svh"
module core_memory_cycle_sequencer
  import core_seq_pkg::*;
#(
  parameter int X_BITS = 7,
  parameter int Y_BITS = 6
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  input  wire logic                    master_req,
  input  wire logic [`CS_ADDR_W-1:0]   bus_addr,
  input  wire logic                    txn_type_line0,
  input  wire logic                    txn_type_line1,
  input  wire logic [`CS_WORD_W-1:0]   bus_data_in,
  input  wire logic                    power_low_indication,
  input  wire logic [3:0]              bank_number,
  input  wire logic [`CS_WORD_W-1:0]   sense_bits,
  output logic                         slave_ack,
  output logic      [`CS_WORD_W-1:0]   bus_data_out,
  output logic                         bus_data_oe,
  output logic      [`CS_X_LINES-1:0]  x_line_en,
  output logic      [`CS_Y_LINES-1:0]  y_line_en,
  output logic                         read_drive,
  output logic                         write_drive,
  output logic                         stack_write_state,
  output logic                         current_src_en,
  output logic      [`CS_WORD_W-1:0]   inhibit_en
);

  if (X_BITS != `CS_X_HI - `CS_X_LO + 1 || Y_BITS != `CS_Y_HI - `CS_Y_LO + 1) begin : g_bad
    $error("core_memory_cycle_sequencer: X/Y widths do not fit the address split");
  end

  seq_s                    st_ff;
  seq_s                    nxt_st;
  logic                    start;
  logic                    busy_nxt;
  logic [`CS_ADDR_W-1:0]   lat_addr;
  logic [`CS_X_LINES-1:0]  x_dec;
  logic [`CS_Y_LINES-1:0]  y_dec;
  txn_e                    bus_txn;

  // R20: control lines to type
  function automatic txn_e decode_txn(input logic c1, input logic c0);
    case ({c1, c0})
      `CS_TXN_RESTORE: decode_txn = READ_RESTORE_TXN;
      `CS_TXN_PAUSE:   decode_txn = READ_PAUSE_TXN;
      `CS_TXN_WORD:    decode_txn = WORD_WRITE_TXN;
      default:         decode_txn = BYTE_WRITE_TXN;
    endcase
  endfunction : decode_txn

  // R2: byte select merges one byte
  function automatic logic [`CS_WORD_W-1:0] merge_byte(
    input logic [`CS_WORD_W-1:0] keep,
    input logic [`CS_WORD_W-1:0] newv,
    input logic                  hi
  );
    merge_byte = hi ? {newv[15:8], keep[7:0]} : {keep[15:8], newv[7:0]};
  endfunction : merge_byte

  function automatic logic is_write(input txn_e t);
    is_write = (t == WORD_WRITE_TXN) || (t == BYTE_WRITE_TXN);
  endfunction : is_write

  assign bus_txn = decode_txn(txn_type_line1, txn_type_line0);

  // R1: take only a selected, fresh request
  // R19: bank compare on top bits
  // R6: no start while power is low
  assign start = (st_ff.state == SEQ_IDLE) && master_req && !st_ff.ack &&
                 !power_low_indication &&
                 (bus_addr[`CS_BANK_HI:`CS_BANK_LO] == bank_number);

  assign lat_addr = start ? bus_addr : st_ff.addr;
  assign busy_nxt = (nxt_st.state != SEQ_IDLE);

  // R3: X and Y halves decoded apart
  line_decoder #(.IN_W(X_BITS)) u_x_dec (
    .sel   (lat_addr[`CS_X_HI:`CS_X_LO]),
    .en    (busy_nxt),
    .lines (x_dec)
  );

  line_decoder #(.IN_W(Y_BITS)) u_y_dec (
    .sel   (lat_addr[`CS_Y_HI:`CS_Y_LO]),
    .en    (busy_nxt),
    .lines (y_dec)
  );

  always_comb begin
    nxt_st = st_ff;
    // R22: answer held until master drops request
    if (!master_req) begin
      nxt_st.ack     = 1'b0;
      nxt_st.data_oe = 1'b0;
    end
    case (st_ff.state)
      SEQ_IDLE: begin
        if (start) begin
          nxt_st.addr = bus_addr;
          // R7: type fixed for the whole cycle
          nxt_st.txn  = bus_txn;
          if (bus_txn == WORD_WRITE_TXN) begin
            nxt_st.data = bus_data_in;
          end else if (bus_txn == BYTE_WRITE_TXN) begin
            // R14: selected byte taken from bus
            nxt_st.data = merge_byte(st_ff.data, bus_data_in, bus_addr[`CS_BYTE_BIT]);
          end
          // R22: write data captured, answer now
          nxt_st.ack = is_write(bus_txn);
          // R13: pause flag skips clearing read
          // R16: byte write treated alike
          if (is_write(bus_txn) && st_ff.pause) begin
            nxt_st.state = SEQ_WRITE;
            nxt_st.cnt   = `CS_CNT_W'(`CS_WRITE_CYC);
          end else begin
            nxt_st.state = SEQ_READ;
            nxt_st.cnt   = `CS_CNT_W'(`CS_READ_CYC);
          end
        end
      end
      SEQ_READ: begin
        nxt_st.cnt = st_ff.cnt - `CS_CNT_W'(1);
        // R17: sense strobe at access time
        if (st_ff.cnt == `CS_CNT_W'(1)) begin
          case (st_ff.txn)
            READ_RESTORE_TXN: begin
              // R8: present data, then restore
              nxt_st.data    = sense_bits;
              nxt_st.ack     = 1'b1;
              nxt_st.data_oe = 1'b1;
              nxt_st.state   = SEQ_WRITE;
              nxt_st.cnt     = `CS_CNT_W'(`CS_WRITE_CYC);
            end
            READ_PAUSE_TXN: begin
              // R9: no restore phase
              // R10: location now cleared
              nxt_st.data    = sense_bits;
              nxt_st.ack     = 1'b1;
              nxt_st.data_oe = 1'b1;
              nxt_st.pause   = 1'b1;
              nxt_st.state   = SEQ_IDLE;
            end
            BYTE_WRITE_TXN: begin
              // R14: keep unselected byte from core
              nxt_st.data  = merge_byte(sense_bits, st_ff.data, st_ff.addr[`CS_BYTE_BIT]);
              nxt_st.state = SEQ_WRITE;
              nxt_st.cnt   = `CS_CNT_W'(`CS_WRITE_CYC);
            end
            default: begin
              // R12: clearing read only, bus data kept
              nxt_st.state = SEQ_WRITE;
              nxt_st.cnt   = `CS_CNT_W'(`CS_WRITE_CYC);
            end
          endcase
        end
      end
      SEQ_WRITE: begin
        nxt_st.cnt = st_ff.cnt - `CS_CNT_W'(1);
        if (st_ff.cnt == `CS_CNT_W'(1)) begin
          nxt_st.state = SEQ_IDLE;
          // R21: pause flag spent by the write
          if (is_write(st_ff.txn)) begin
            nxt_st.pause = 1'b0;
          end
        end
      end
      default: begin
        nxt_st.state = SEQ_IDLE;
      end
    endcase
    // R6: power low aborts any cycle
    if (power_low_indication) begin
      nxt_st.state = SEQ_IDLE;
    end
    // R4: separate read and write drive
    nxt_st.rd_drv   = (nxt_st.state == SEQ_READ);
    nxt_st.wr_drv   = (nxt_st.state == SEQ_WRITE);
    // R5: stack discharge follows phase
    nxt_st.stack_wr = (nxt_st.state == SEQ_WRITE);
    // R15: whole register written back
    // R18: inhibit drivers for zero bits
    nxt_st.inhibit  = (nxt_st.state == SEQ_WRITE) ? ~nxt_st.data : '0;
    nxt_st.src_en   = !power_low_indication && busy_nxt;
    nxt_st.x_en     = x_dec;
    nxt_st.y_en     = y_dec;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{state: SEQ_IDLE, txn: READ_RESTORE_TXN, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign slave_ack         = st_ff.ack;
  assign bus_data_out      = st_ff.data;
  assign bus_data_oe       = st_ff.data_oe;
  assign x_line_en         = st_ff.x_en;
  assign y_line_en         = st_ff.y_en;
  assign read_drive        = st_ff.rd_drv;
  assign write_drive       = st_ff.wr_drv;
  assign stack_write_state = st_ff.stack_wr;
  assign current_src_en    = st_ff.src_en;
  assign inhibit_en        = st_ff.inhibit;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_power_blocks_src: assert property ( // R6
    power_low_indication |=> !current_src_en && !read_drive && !write_drive)
    else $error("current source enabled under power low");

  a_drive_opposite: assert property ( // R4
    !(read_drive && write_drive))
    else $error("read and write drive together");

  a_stack_phase: assert property ( // R5
    (read_drive |-> !stack_write_state) and (write_drive |-> stack_write_state))
    else $error("stack state does not follow phase");

  a_xy_one_line: assert property ( // R3
    (read_drive || write_drive) |-> $onehot(x_line_en) && $onehot(y_line_en))
    else $error("not exactly one X and one Y line");

  a_read_ten_cycles: assert property ( // R17
    $rose(read_drive) ##0 (read_drive && !power_low_indication) [*8] ##1
      (read_drive && !power_low_indication) |=> read_drive ##1 !read_drive)
    else $error("read phase length wrong");

  a_pause_skips_read: assert property ( // R13
    start && st_ff.pause && is_write(bus_txn) |=> write_drive && !read_drive)
    else $error("write after pause did not skip read");

  a_pause_flag_set: assert property ( // R10
    st_ff.state == SEQ_READ && st_ff.txn == READ_PAUSE_TXN && st_ff.cnt == 5'h01 &&
    !power_low_indication |=> st_ff.pause && slave_ack && !write_drive)
    else $error("pause read did not set flag");

  a_pause_flag_clear: assert property ( // R21
    write_drive && is_write(st_ff.txn) && st_ff.cnt == 5'h01 |=> !st_ff.pause)
    else $error("pause flag not cleared after write");

  a_inhibit_zeros: assert property ( // R18
    write_drive |-> inhibit_en == ~bus_data_out)
    else $error("inhibit does not match zero bits");

  a_ack_after_data: assert property ( // R22
    $rose(slave_ack) && !is_write(st_ff.txn) |->
      bus_data_oe && st_ff.addr[`CS_BANK_HI:`CS_BANK_LO] == bank_number)
    else $error("read answered without data");

  a_word_write_ack: assert property ( // R22
    start && is_write(bus_txn) |=> slave_ack && !bus_data_oe)
    else $error("write not answered after capture");

  a_restore_write_back: assert property ( // R8
    st_ff.state == SEQ_READ && st_ff.txn == READ_RESTORE_TXN && st_ff.cnt == 5'h01 &&
    !power_low_indication |=> write_drive && bus_data_oe && bus_data_out == $past(sense_bits))
    else $error("restore read did not present and write back");

  a_byte_keeps_other: assert property ( // R14
    st_ff.state == SEQ_READ && st_ff.txn == BYTE_WRITE_TXN && st_ff.cnt == 5'h01 &&
    !power_low_indication |=> write_drive &&
      (st_ff.addr[`CS_BYTE_BIT] ? bus_data_out[7:0] == $past(sense_bits[7:0]) :
                                  bus_data_out[15:8] == $past(sense_bits[15:8])))
    else $error("byte write lost the unselected byte");

  c_restore_read: cover property (
    $rose(read_drive) && st_ff.txn == READ_RESTORE_TXN ##[10:12] write_drive);
  c_pause_then_word: cover property (
    $rose(st_ff.pause) ##[1:40] $rose(write_drive) && st_ff.txn == WORD_WRITE_TXN);
  c_byte_write: cover property (
    read_drive && st_ff.txn == BYTE_WRITE_TXN ##[1:12] write_drive);
  c_pause_then_byte: cover property (
    $rose(st_ff.pause) ##[1:40] $rose(write_drive) && st_ff.txn == BYTE_WRITE_TXN);
  c_power_abort: cover property (
    read_drive && power_low_indication ##1 !read_drive);

endmodule : core_memory_cycle_sequencer

// ==== include/core_seq_cfg.svh ====
`ifndef CORE_SEQ_CFG_SVH
`define CORE_SEQ_CFG_SVH

`define CS_ADDR_W     18
`define CS_WORD_W     16
`define CS_BANK_HI    17
`define CS_BANK_LO    14
`define CS_Y_HI       13
`define CS_Y_LO       8
`define CS_X_HI       7
`define CS_X_LO       1
`define CS_BYTE_BIT   0
`define CS_X_LINES    128
`define CS_Y_LINES    64
`define CS_CNT_W      5

`define CS_CLK_NS     40
`define CS_ACCESS_NS  400
`define CS_CYCLE_NS   900
// longest times: round down
`define CS_READ_CYC   (`CS_ACCESS_NS / `CS_CLK_NS)
`define CS_WRITE_CYC  ((`CS_CYCLE_NS - `CS_ACCESS_NS) / `CS_CLK_NS)

`define CS_TXN_RESTORE 2'h0
`define CS_TXN_PAUSE   2'h1
`define CS_TXN_WORD    2'h2
`define CS_TXN_BYTE    2'h3

`endif

// ==== include/core_seq_pkg.sv ====
`include "core_seq_cfg.svh"

package core_seq_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_READ,
    SEQ_WRITE
  } seq_e;

  typedef enum logic [1:0] {
    READ_RESTORE_TXN,
    READ_PAUSE_TXN,
    WORD_WRITE_TXN,
    BYTE_WRITE_TXN
  } txn_e;

  typedef struct packed {
    seq_e                    state;
    txn_e                    txn;
    logic [`CS_ADDR_W-1:0]   addr;
    logic [`CS_WORD_W-1:0]   data;
    logic [`CS_CNT_W-1:0]    cnt;
    logic                    pause;
    logic                    ack;
    logic                    data_oe;
    logic                    rd_drv;
    logic                    wr_drv;
    logic                    stack_wr;
    logic                    src_en;
    logic [`CS_WORD_W-1:0]   inhibit;
    logic [`CS_X_LINES-1:0]  x_en;
    logic [`CS_Y_LINES-1:0]  y_en;
  } seq_s;

endpackage : core_seq_pkg

// ==== rtl/line_decoder.sv ====
module line_decoder #(
  parameter int IN_W = 6
) (
  input  wire logic [IN_W-1:0]     sel,
  input  wire logic                en,
  output logic      [2**IN_W-1:0]  lines
);

  if (IN_W < 1 || IN_W > 10) begin : g_bad_width
    $error("line_decoder: IN_W out of range");
  end

  // exactly one line when enabled
  always_comb begin
    lines      = '0;
    lines[sel] = en;
  end

endmodule : line_decoder

// ==== tb/core_stack_model.sv ====
`include "core_seq_cfg.svh"
module core_stack_model (
  input  wire logic                    mclk,
  input  wire logic [`CS_X_LINES-1:0]  x_line_en,
  input  wire logic [`CS_Y_LINES-1:0]  y_line_en,
  input  wire logic                    read_drive,
  input  wire logic                    write_drive,
  input  wire logic                    current_src_en,
  input  wire logic [`CS_WORD_W-1:0]   inhibit_en,
  output logic      [`CS_WORD_W-1:0]   sense_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`CS_WORD_W-1:0] mem [0:8191];
  logic [12:0]           rd_idx_ff;
  logic [12:0]           wr_idx_ff;
  logic [`CS_WORD_W-1:0] wr_val_ff;
  logic                  rd_seen_ff = 1'b0;
  logic                  wr_seen_ff = 1'b0;
  function automatic logic [12:0] word_idx();
    logic [12:0] r;
    r = '0;
    for (int i = 0; i < `CS_X_LINES; i++) if (x_line_en[i]) r[6:0] = i[6:0];
    for (int j = 0; j < `CS_Y_LINES; j++) if (y_line_en[j]) r[12:7] = j[5:0];
    return r;
  endfunction : word_idx
  initial begin
    sense_bits = 16'hA5A5;
    for (int k = 0; k < 8192; k++) mem[k] = 16'h0000;
  end
  always @(posedge mclk) begin
    if (read_drive && current_src_en) begin
      sense_bits <= mem[word_idx()];
      rd_idx_ff  <= word_idx();
      rd_seen_ff <= 1'b1;
    end else begin
      // sense idle toggles so stale data is never seen
      sense_bits <= ~sense_bits;
      if (rd_seen_ff) mem[rd_idx_ff] <= 16'h0000;
      rd_seen_ff <= 1'b0;
    end
    // write polarity sets ones unless inhibited
    if (write_drive && current_src_en) begin
      wr_val_ff  <= ~inhibit_en;
      wr_idx_ff  <= word_idx();
      wr_seen_ff <= 1'b1;
    end else begin
      if (wr_seen_ff) mem[wr_idx_ff] <= wr_val_ff;
      wr_seen_ff <= 1'b0;
    end
  end
endmodule : core_stack_model

// ==== tb/core_memory_cycle_sequencer_tb_top.sv ====
`include "core_seq_cfg.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module core_memory_cycle_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] t; logic [17:0] a; logic [15:0] d; logic [15:0] q;
                  logic [1:0] ph;} row_s;
  localparam logic [1:0]  t_rr = `CS_TXN_RESTORE;
  localparam logic [1:0]  t_rp = `CS_TXN_PAUSE;
  localparam logic [1:0]  t_ww = `CS_TXN_WORD;
  localparam logic [1:0]  t_bw = `CS_TXN_BYTE;
  localparam logic [17:0] aa   = {4'h5, 6'h12, 7'h34, 1'b0};
  localparam logic [17:0] ab   = {4'h5, 6'h21, 7'h43, 1'b0};
  logic mclk = 1'b0, rst_b = 1'b0, master_req = 1'b0, power_low_indication = 1'b0;
  logic txn_type_line0 = 1'b0, txn_type_line1 = 1'b0;
  logic [17:0] bus_addr = '0;
  logic [15:0] bus_data_in = '0, sense_bits, bus_data_out, inhibit_en;
  logic [3:0]  bank_number = 4'h5;
  logic slave_ack, bus_data_oe, read_drive, write_drive, stack_write_state, current_src_en;
  logic [`CS_X_LINES-1:0] x_line_en;
  logic [`CS_Y_LINES-1:0] y_line_en;
  int miscompares = 0, checks_done = 0, seen;
  // every pause read followed by a write to it
  row_s rows [15] = '{
    '{t_ww, aa, 16'h1234, 16'h0, 2'b10}, '{t_rr, aa, 16'h0, 16'h1234, 2'b01},
    '{t_rr, aa, 16'h0, 16'h1234, 2'b01}, '{t_bw, aa | 18'h1, 16'hAB00, 16'h0, 2'b10},
    '{t_rr, aa, 16'h0, 16'hAB34, 2'b01}, '{t_bw, aa, 16'h00CD, 16'h0, 2'b10},
    '{t_rr, aa, 16'h0, 16'hABCD, 2'b01}, '{t_rp, aa, 16'h0, 16'hABCD, 2'b00},
    '{t_ww, aa, 16'h5555, 16'h0, 2'b01}, '{t_rr, aa, 16'h0, 16'h5555, 2'b01},
    '{t_rp, aa, 16'h0, 16'h5555, 2'b00}, '{t_bw, aa | 18'h1, 16'h7700, 16'h0, 2'b01},
    '{t_ww, ab, 16'h0F0F, 16'h0, 2'b10}, '{t_rr, aa, 16'h0, 16'h7755, 2'b01},
    '{t_rr, ab, 16'h0, 16'h0F0F, 2'b01}};
  always #20 mclk = ~mclk;
  core_memory_cycle_sequencer u_core_memory_cycle_sequencer (.*);
  core_stack_model u_core_stack_model (.*);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic txn(input row_s r);
    int n;
    int m;
    n = 0;
    m = 0;
    @(posedge mclk);
    bus_addr <= r.a;
    bus_data_in <= r.d;
    {txn_type_line1, txn_type_line0} <= r.t;
    master_req <= 1'b1;
    do begin @(negedge mclk); n++; end while (slave_ack !== 1'b1 && n < 60);
    if (n >= 60) begin miscompares++; end_sim(); end
    `CHK("latency", (r.t[1] ? 2 : `CS_READ_CYC + 2), n)
    `CHK("oe", ~r.t[1], bus_data_oe)
    if (!r.t[1]) `CHK("rdata", r.q, bus_data_out)
    `CHK("phase", r.ph, {read_drive, write_drive})
    `CHK("stack", r.ph[0], stack_write_state)
    `CHK("src_en", r.ph != 2'b00, current_src_en)
    if (r.ph != 2'b00) `CHK("lines", 1'b1, $onehot(x_line_en) && x_line_en[r.a[7:1]] &&
                              $onehot(y_line_en) && y_line_en[r.a[13:8]])
    if (r.ph == 2'b01 && r.t != t_bw) `CHK("inhibit", ~(r.t[1] ? r.d : r.q), inhibit_en)
    @(posedge mclk);
    master_req <= 1'b0;
    do begin @(negedge mclk); m++; end
    while ({slave_ack, read_drive, write_drive} !== 3'b000 && m < 60);
    if (m >= 60) begin miscompares++; end_sim(); end
    if (r.t[1]) `CHK("short_wr", r.ph[0], m <= `CS_WRITE_CYC + 2)
    else `CHK("short_rd", r.ph == 2'b00, m <= 2)
    repeat (2) @(posedge mclk);
  endtask : txn
  task automatic quiet(input logic [17:0] a, input int pre, input logic pl);
    @(posedge mclk);
    bus_addr <= a;
    {txn_type_line1, txn_type_line0} <= t_rr;
    master_req <= 1'b1;
    power_low_indication <= pl && pre == 0;
    repeat (pre) @(negedge mclk);
    @(posedge mclk);
    power_low_indication <= pl;
    repeat (2) @(negedge mclk);
    seen = 0;
    repeat (25) begin
      @(negedge mclk);
      if ({slave_ack, current_src_en, read_drive, write_drive} !== 4'h0) seen++;
    end
    @(posedge mclk);
    master_req <= 1'b0;
    power_low_indication <= 1'b0;
    repeat (30) @(posedge mclk);
  endtask : quiet
  initial begin
    repeat (12) @(negedge mclk);
    `CHK("reset", 1'b0, |{slave_ack, bus_data_oe, current_src_en, read_drive, write_drive,
                          stack_write_state, inhibit_en, x_line_en, y_line_en})
    @(posedge mclk);
    rst_b <= 1'b1;
    foreach (rows[i]) txn(rows[i]);
    quiet({4'hA, aa[13:0]}, 0, 1'b0);
    `CHK("other_bank", 0, seen)
    quiet(aa, 0, 1'b1);
    `CHK("power_low", 0, seen)
    // mid-cycle abort drops drive, no answer given
    quiet(ab, 5, 1'b1);
    `CHK("abort", 0, seen)
    end_sim();
  end
endmodule : core_memory_cycle_sequencer_tb_top
